/* File: core/gpir_pkg.sv */
// Purpose: constants and carrier types for the gpio ports with ir modulation
// Assumes: 8-bit special function register bus from the core
// Notes: one file of constants shared by the port block
package gpir_pkg;
  localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
  localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
  localparam logic [7:0] ADDR_MOD_SELECT = 8'h9f;
  localparam logic [7:0] ADDR_PORT2_LATCH = 8'ha0;
  localparam logic [7:0] ADDR_PORT0_PUDIS = 8'hb2;
  localparam logic [7:0] ADDR_PORT1_PUDIS = 8'hb3;
  localparam logic [7:0] ADDR_PORT2_PUDIS = 8'hb4;
  localparam logic [7:0] LATCH_RESET = 8'hff;
  localparam logic [7:0] PUDIS_RESET = 8'h00;
  localparam logic [7:0] MODSEL_RESET = 8'h00;
  localparam logic [7:0] PORT2_PUDIS_MASK = 8'h27;
  localparam int PORT2_RESET_PIN_BIT = 5;
  // modulation select bit positions: port, pin
  localparam int MOD_P1B6 = 7;
  localparam int MOD_P1B5 = 6;
  localparam int MOD_P1B4 = 5;
  localparam int MOD_P1B1 = 4;
  localparam int MOD_P0B2 = 3;
  localparam int MOD_P0B7 = 2;
  localparam int MOD_P0B5 = 1;
  localparam int MOD_P0B3 = 0;
  localparam int CORE_CLK_HZ = 125000000;
  localparam int MOD_FREQ_HZ = 38000;
  // half period in clocks for a 50 percent square wave
  localparam int MOD_HALF_CYCLES = CORE_CLK_HZ / (2 * MOD_FREQ_HZ);
  localparam int MOD_CNT_W = 12;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr_latch;
    logic rd_latch;
    logic rd_pin;
  } gpir_sfr_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpir_pad_t;
endpackage : gpir_pkg

/* File: core/gpir_ports.sv */
// Purpose: three 8-bit ports, pull-up control, 38 kHz modulation
// Assumes: pins outside the clock domain, peripherals on the core clock
// Notes: pins drive only low; high comes from the weak pull-up
//
// Notes on behaviour
// R1: write strobe loads addressed port latch
// R2: read-latch strobe returns latch contents
// R3: read-pin strobe returns synchronised pin levels
// R4: instruction picks latch or pin path
// R5: per-pin pull-ups, all enabled after reset
// R6: pull-up disabled pin is open drain
// R7: software writes 1 before input use
// R8: output pin follows latch low or high
// R9: open-drain input needs latch 1
// R10: enabled peripheral owns its pin
// R11: selected pin output is latch xor wave
// R12: global enable gates all modulation
// R13: select register bit map, reset cleared
// R14: port 0 pull-up disable register
// R15: ports 1 and 2 pull-up registers
// R16: port 1 bit n disables pull-up
// R17: port 2 bits 2..0 and reset pin
// R18: software keeps latch 1 for peripherals
// R19: unselected pins follow latch directly
// R20: wave is divided clock, 50 percent duty
`timescale 1ns/1ns
module gpir_ports
  import gpir_pkg::*;
#(
  parameter int HALF_CYCLES = MOD_HALF_CYCLES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire gpir_pkg::gpir_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic global_ir_modulation_enable,
  input wire logic [23:0] periph_en,
  input wire logic [23:0] periph_out,
  input wire logic [23:0] pin_in,
  output logic [23:0] periph_in,
  output logic [23:0] pin_out,
  output logic [23:0] pin_oe,
  output logic [23:0] pin_pullup_en,
  output logic reset_pin_pullup_en
);
  import gpir_pkg::*;

  // ==========================================================
  // registers
  logic [7:0] port0_latch_q, port0_latch_d;
  logic [7:0] port1_latch_q, port1_latch_d;
  logic [7:0] port2_latch_q, port2_latch_d;
  logic [7:0] modulation_pin_select_q, modulation_pin_select_d;
  logic [7:0] port0_pullup_disable_q, port0_pullup_disable_d;
  logic [7:0] port1_pullup_disable_q, port1_pullup_disable_d;
  logic [7:0] port2_pullup_disable_q, port2_pullup_disable_d;
  logic [7:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  logic [23:0] sync1_q, sync2_q;
  logic [23:0] latch_all, pudis_all, modsel_map, drive_level;
  logic [23:0] out_q, out_d, oe_q, oe_d, pu_q, pu_d, pin_rd_q;
  logic rst_pu_q, rst_pu_d;
  logic [MOD_CNT_W-1:0] mod_cnt_q, mod_cnt_d;
  logic wave_q, wave_d;

  always_comb
  begin
    port0_latch_d = port0_latch_q;
    port1_latch_d = port1_latch_q;
    port2_latch_d = port2_latch_q;
    modulation_pin_select_d = modulation_pin_select_q;
    port0_pullup_disable_d = port0_pullup_disable_q;
    port1_pullup_disable_d = port1_pullup_disable_q;
    port2_pullup_disable_d = port2_pullup_disable_q;
    if (sfr_req.wr_latch)
    begin
      if (sfr_req.addr == ADDR_PORT0_LATCH)
        port0_latch_d = sfr_req.wdata; // see R1
      else if (sfr_req.addr == ADDR_PORT1_LATCH)
        port1_latch_d = sfr_req.wdata; // see R1
      else if (sfr_req.addr == ADDR_PORT2_LATCH)
        port2_latch_d = sfr_req.wdata; // see R1
      else if (sfr_req.addr == ADDR_MOD_SELECT)
        modulation_pin_select_d = sfr_req.wdata; // see R13
      else if (sfr_req.addr == ADDR_PORT0_PUDIS)
        port0_pullup_disable_d = sfr_req.wdata; // see R14
      else if (sfr_req.addr == ADDR_PORT1_PUDIS)
        port1_pullup_disable_d = sfr_req.wdata; // see R15 see R16
      else if (sfr_req.addr == ADDR_PORT2_PUDIS)
        port2_pullup_disable_d = sfr_req.wdata & PORT2_PUDIS_MASK; // see R15 see R17
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      port0_latch_q <= LATCH_RESET;
      port1_latch_q <= LATCH_RESET;
      port2_latch_q <= LATCH_RESET;
      modulation_pin_select_q <= MODSEL_RESET;
      port0_pullup_disable_q <= PUDIS_RESET; // see R5
      port1_pullup_disable_q <= PUDIS_RESET;
      port2_pullup_disable_q <= PUDIS_RESET;
    end
    else
    begin
      port0_latch_q <= port0_latch_d;
      port1_latch_q <= port1_latch_d;
      port2_latch_q <= port2_latch_d;
      modulation_pin_select_q <= modulation_pin_select_d;
      port0_pullup_disable_q <= port0_pullup_disable_d;
      port1_pullup_disable_q <= port1_pullup_disable_d;
      port2_pullup_disable_q <= port2_pullup_disable_d;
    end
  end

  // ==========================================================
  // pin synchroniser
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync1_q <= {24{1'b1}};
      sync2_q <= {24{1'b1}};
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================================
  // read paths
  always_comb
  begin
    rdata_d = rdata_q;
    rvalid_d = sfr_req.rd_latch | sfr_req.rd_pin;
    if (sfr_req.rd_latch) // see R2 see R4
    begin
      if (sfr_req.addr == ADDR_PORT0_LATCH)
        rdata_d = port0_latch_q;
      else if (sfr_req.addr == ADDR_PORT1_LATCH)
        rdata_d = port1_latch_q;
      else if (sfr_req.addr == ADDR_PORT2_LATCH)
        rdata_d = port2_latch_q;
      else if (sfr_req.addr == ADDR_MOD_SELECT)
        rdata_d = modulation_pin_select_q;
      else if (sfr_req.addr == ADDR_PORT0_PUDIS)
        rdata_d = port0_pullup_disable_q;
      else if (sfr_req.addr == ADDR_PORT1_PUDIS)
        rdata_d = port1_pullup_disable_q;
      else if (sfr_req.addr == ADDR_PORT2_PUDIS)
        rdata_d = port2_pullup_disable_q;
      else
        rdata_d = 8'h00;
    end
    else if (sfr_req.rd_pin) // see R3 see R4
    begin
      if (sfr_req.addr == ADDR_PORT0_LATCH)
        rdata_d = sync2_q[7:0];
      else if (sfr_req.addr == ADDR_PORT1_LATCH)
        rdata_d = sync2_q[15:8];
      else if (sfr_req.addr == ADDR_PORT2_LATCH)
        rdata_d = sync2_q[23:16];
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ==========================================================
  // 38 kHz square wave
  always_comb
  begin
    mod_cnt_d = mod_cnt_q + 1'b1;
    wave_d = wave_q;
    if (mod_cnt_q == MOD_CNT_W'(HALF_CYCLES - 1))
    begin
      mod_cnt_d = '0;
      wave_d = ~wave_q; // see R20
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mod_cnt_q <= '0;
      wave_q <= 1'b0;
    end
    else
    begin
      mod_cnt_q <= mod_cnt_d;
      wave_q <= wave_d;
    end
  end

  // ==========================================================
  // pad drive
  always_comb
  begin
    latch_all = {port2_latch_q, port1_latch_q, port0_latch_q};
    pudis_all = {port2_pullup_disable_q, port1_pullup_disable_q, port0_pullup_disable_q};
    modsel_map = '0; // see R13
    modsel_map[8 + 6] = modulation_pin_select_q[MOD_P1B6];
    modsel_map[8 + 5] = modulation_pin_select_q[MOD_P1B5];
    modsel_map[8 + 4] = modulation_pin_select_q[MOD_P1B4];
    modsel_map[8 + 1] = modulation_pin_select_q[MOD_P1B1];
    modsel_map[2] = modulation_pin_select_q[MOD_P0B2];
    modsel_map[7] = modulation_pin_select_q[MOD_P0B7];
    modsel_map[5] = modulation_pin_select_q[MOD_P0B5];
    modsel_map[3] = modulation_pin_select_q[MOD_P0B3];
    // see R11 see R12 see R19
    drive_level = latch_all ^ (modsel_map & {24{global_ir_modulation_enable & wave_q}});
    drive_level = (periph_en & periph_out) | (~periph_en & drive_level); // see R10
    out_d = '0; // see R6
    oe_d = ~drive_level; // see R8
    pu_d = ~pudis_all; // see R5 see R14 see R16
    pu_d[23:19] = '0;
    pu_d[18:16] = ~port2_pullup_disable_q[2:0]; // see R17
    rst_pu_d = ~port2_pullup_disable_q[PORT2_RESET_PIN_BIT];
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_q <= '0;
      oe_q <= '0;
      pu_q <= {5'h00, 3'h7, 16'hffff};
      rst_pu_q <= 1'b1;
      pin_rd_q <= {24{1'b1}};
    end
    else
    begin
      out_q <= out_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
      rst_pu_q <= rst_pu_d;
      pin_rd_q <= sync2_q;
    end
  end

  assign sfr_rdata = rdata_q;
  assign sfr_rvalid = rvalid_q;
  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign pin_pullup_en = pu_q;
  assign reset_pin_pullup_en = rst_pu_q;
  assign periph_in = pin_rd_q;

  // ==========================================================
  // checks
  sequence s_wr_p0;
    sfr_req.wr_latch && sfr_req.addr == ADDR_PORT0_LATCH;
  endsequence

  property p_write_latch;
    @(posedge clock) disable iff (sys_rst)
    s_wr_p0 |=> port0_latch_q == $past(sfr_req.wdata);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch write lost"); // see R1

  property p_read_latch;
    @(posedge clock) disable iff (sys_rst)
    (sfr_req.rd_latch && sfr_req.addr == ADDR_PORT1_LATCH) |=> sfr_rdata == $past(port1_latch_q);
  endproperty
  a_read_latch: assert property (p_read_latch) else $error("latch read wrong"); // see R2

  property p_read_pin;
    @(posedge clock) disable iff (sys_rst)
    (!sfr_req.rd_latch && sfr_req.rd_pin && sfr_req.addr == ADDR_PORT0_LATCH) |=> sfr_rdata == $past(sync2_q[7:0]);
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("pin read wrong"); // see R3

  property p_never_high;
    @(posedge clock) disable iff (sys_rst)
    pin_out == 24'h000000;
  endproperty
  a_never_high: assert property (p_never_high) else $error("pin driven high"); // see R6

  property p_follow_latch;
    @(posedge clock) disable iff (sys_rst)
    (!periph_en[0] && !modsel_map[0]) |=> pin_oe[0] == !$past(port0_latch_q[0]);
  endproperty
  a_follow_latch: assert property (p_follow_latch) else $error("pin not following latch"); // see R8

  property p_periph_owns;
    @(posedge clock) disable iff (sys_rst)
    periph_en[9] |=> pin_oe[9] == !$past(periph_out[9]);
  endproperty
  a_periph_owns: assert property (p_periph_owns) else $error("peripheral lost pin"); // see R10

  property p_mod_xor;
    @(posedge clock) disable iff (sys_rst)
    (!periph_en[3] && global_ir_modulation_enable && modulation_pin_select_q[MOD_P0B3])
      |=> pin_oe[3] == ($past(port0_latch_q[3]) == $past(wave_q));
  endproperty
  a_mod_xor: assert property (p_mod_xor) else $error("modulation xor wrong"); // see R11

  property p_mod_gated;
    @(posedge clock) disable iff (sys_rst)
    (!periph_en[14] && !global_ir_modulation_enable) |=> pin_oe[14] == !$past(port1_latch_q[6]);
  endproperty
  a_mod_gated: assert property (p_mod_gated) else $error("modulation not gated"); // see R12

  property p_pullup;
    @(posedge clock) disable iff (sys_rst)
    1'b1 |=> pin_pullup_en[7:0] == ~$past(port0_pullup_disable_q);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up control wrong"); // see R14

  property p_wave_toggle;
    @(posedge clock) disable iff (sys_rst)
    $changed(wave_q) |-> $past(mod_cnt_q) == MOD_CNT_W'(HALF_CYCLES - 1);
  endproperty
  a_wave_toggle: assert property (p_wave_toggle) else $error("wave period wrong"); // see R20
endmodule : gpir_ports

/* File: bench/gpir_pin_model.sv */
// Purpose: external devices and wiring on the 24 port pins
// Assumes: design pulls pins low only; pull-ups are weak
// Notes: undriven pins without pull-up float to a changing level
`timescale 1ns/1ns
module gpir_pin_model
(
  input wire logic clock,
  input wire logic [23:0] pin_out,
  input wire logic [23:0] pin_oe,
  input wire logic [23:0] pin_pullup_en,
  input wire logic [23:0] ext_low,
  output logic [23:0] pin_level
);
  // ==========================================
  // wired level of each pin
  logic [23:0] float_q = 24'h0;
  always @(posedge clock) float_q <= ~float_q;
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      if (pin_oe[i] === 1'b1)
        pin_level[i] = pin_out[i];
      else if (ext_low[i] === 1'b1)
        pin_level[i] = 1'b0;
      else if (pin_pullup_en[i] === 1'b1)
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_q[i];
    end
  end
endmodule : gpir_pin_model

/* File: bench/gpio_ports_with_ir_modulation_tb_top.sv */
// Purpose: self-checking bench for the port block
// Assumes: inputs driven at falling edge, short wave half period
// Notes: one task per scenario
`timescale 1ns/1ns
module gpio_ports_with_ir_modulation_tb_top;
  import gpir_pkg::*;
  localparam int HC = 4;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  gpir_sfr_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] rd;
  logic rvalid;
  logic rst_pu;
  logic gmod = 1'b0;
  logic [23:0] pen = '0;
  logic [23:0] pout = '1;
  logic [23:0] ext_low = '0;
  logic [23:0] pins;
  logic [23:0] pin_out;
  logic [23:0] oe;
  logic [23:0] pu;
  logic [23:0] pin_sync;
  int failures = 0;
  int n_tests = 0;
  always #4 clock = ~clock;

  gpir_ports #(.HALF_CYCLES(HC)) gpir_ports_i (.clock(clock), .sys_rst(sys_rst), .sfr_req(req),
    .sfr_rdata(rdata), .sfr_rvalid(rvalid), .global_ir_modulation_enable(gmod), .periph_en(pen),
    .periph_out(pout), .pin_in(pins), .periph_in(pin_sync), .pin_out(pin_out), .pin_oe(oe),
    .pin_pullup_en(pu), .reset_pin_pullup_en(rst_pu));
  gpir_pin_model gpir_pin_model_i (.clock(clock), .pin_out(pin_out), .pin_oe(oe),
    .pin_pullup_en(pu), .ext_low(ext_low), .pin_level(pins));

  // ==========================================
  // shared tasks
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] kind);
    @(negedge clock);
    req = '{addr: a, wdata: d, wr_latch: kind[2], rd_latch: kind[1], rd_pin: kind[0]};
    @(negedge clock);
    req = '0;
    rd = rdata;
    if (kind[2] == 1'b0) check({23'h0, rvalid}, 24'h1);
  endtask : sfr
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr(a, d, 3'b100);
  endtask : wr
  task automatic rl(input logic [7:0] a, input logic [7:0] exp);
    sfr(a, 8'h00, 3'b010);
    check({16'h0, rd}, {16'h0, exp});
  endtask : rl
  task automatic rp(input logic [7:0] a, input logic [7:0] exp);
    sfr(a, 8'h00, 3'b001);
    check({16'h0, rd}, {16'h0, exp});
  endtask : rp
  task automatic count_hi(input int idx, output int n);
    n = 0;
    repeat (16)
    begin
      @(negedge clock);
      if (oe[idx] === 1'b1) n++;
    end
  endtask : count_hi

  // ==========================================
  // scenarios
  task automatic t_reset;
    rl(ADDR_PORT0_LATCH, LATCH_RESET);
    rl(ADDR_PORT1_LATCH, LATCH_RESET);
    rl(ADDR_PORT2_LATCH, LATCH_RESET);
    rl(ADDR_MOD_SELECT, 8'h00);
    rl(ADDR_PORT0_PUDIS, 8'h00);
    rl(ADDR_PORT1_PUDIS, 8'h00);
    rl(ADDR_PORT2_PUDIS, 8'h00);
    check(pu, 24'h07ffff);
    check({23'h0, rst_pu}, 24'h1);
    check(oe, 24'h0);
  endtask : t_reset
  task automatic t_latch;
    wr(ADDR_PORT0_LATCH, 8'h5a);
    cyc(1);
    check({16'h0, oe[7:0]}, 24'ha5);
    rl(ADDR_PORT0_LATCH, 8'h5a);
    cyc(3);
    rp(ADDR_PORT0_LATCH, 8'h5a);
    ext_low[15:8] = 8'h0f;
    cyc(4);
    rp(ADDR_PORT1_LATCH, 8'hf0);
    rl(ADDR_PORT1_LATCH, 8'hff);
    check({16'h0, pin_sync[15:8]}, 24'hf0);
    ext_low = '0;
    wr(ADDR_PORT0_LATCH, 8'hff);
  endtask : t_latch
  task automatic t_pullup;
    wr(ADDR_PORT0_PUDIS, 8'h0f);
    wr(ADDR_PORT1_PUDIS, 8'hf0);
    wr(ADDR_PORT2_PUDIS, 8'hff);
    rl(ADDR_PORT2_PUDIS, 8'h27);
    rl(ADDR_PORT1_PUDIS, 8'hf0);
    check(pu, 24'h000ff0);
    check({23'h0, rst_pu}, 24'h0);
    wr(ADDR_PORT0_LATCH, 8'hfe);
    cyc(1);
    check({16'h0, oe[7:0]}, 24'h01);
    check(pin_out, 24'h0);
    wr(ADDR_PORT0_LATCH, 8'hff);
    wr(ADDR_PORT0_PUDIS, 8'h00);
    wr(ADDR_PORT1_PUDIS, 8'h00);
    wr(ADDR_PORT2_PUDIS, 8'h00);
  endtask : t_pullup
  task automatic t_mod;
    int pin_of [8] = '{3, 5, 7, 2, 9, 12, 13, 14};
    int n;
    gmod = 1'b1;
    wr(ADDR_PORT0_LATCH, 8'h00);
    wr(ADDR_PORT1_LATCH, 8'h00);
    for (int b = 0; b < 8; b++)
    begin
      wr(ADDR_MOD_SELECT, 8'h01 << b);
      count_hi(pin_of[b], n);
      check(24'(n), 24'd8);
    end
    count_hi(0, n);
    check(24'(n), 24'd16);
    gmod = 1'b0;
    cyc(1);
    count_hi(14, n);
    check(24'(n), 24'd16);
    wr(ADDR_MOD_SELECT, 8'h00);
    wr(ADDR_PORT0_LATCH, 8'hff);
    wr(ADDR_PORT1_LATCH, 8'hff);
  endtask : t_mod
  task automatic t_periph;
    pen[9:8] = 2'b11;
    pout[9:8] = 2'b00;
    cyc(2);
    check({22'h0, oe[9:8]}, 24'h3);
    pout[9:8] = 2'b11;
    cyc(2);
    check({22'h0, oe[9:8]}, 24'h0);
    pen = '0;
  endtask : t_periph
  task automatic t_unmapped;
    wr(8'h55, 8'h00);
    rl(8'h55, 8'h00);
    rp(ADDR_MOD_SELECT, 8'h00);
    rl(ADDR_PORT0_LATCH, 8'hff);
  endtask : t_unmapped

  // ==========================================
  // closing report
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  initial
  begin
    cyc(16);
    sys_rst = 1'b0;
    t_reset();
    t_latch();
    t_pullup();
    t_mod();
    t_periph();
    t_unmapped();
    wrap_up();
  end
endmodule : gpio_ports_with_ir_modulation_tb_top
